//--- logic/dcf_fifo_flags.sv
// Dual-clock FIFO with status flags, fall-through option and clock select.
// Assumes: clock is the write clock, read_clock the read clock; reset pins
// and strap pins are asynchronous; write and read strobes are synchronous
// to their own port clocks.
`timescale 1ns/1ps

// Contract
// - Select high: write-clock view drives half-full, else read
// - Idle port clock freezes its own flags
// - Standard mode: full at depth, writes ignored
// - Fall-through: input-ready high at depth plus one
// - Input-ready count includes the output register
// - Full/input-ready through two write-clock stages
// - Standard mode: empty at zero, reads ignored
// - No read until empty flag deasserts
// - Output-ready follows output register occupancy
// - Fall-through latency one read cycle longer
// - Empty/output-ready through two read-clock stages
// - Almost-full low from depth minus m
// - Standard flags follow stored word count
// - Output register word excluded from count
// - Default empty offset 127 parallel, 1023 serial
// - Default full offset 127 parallel, 1023 serial
// - Almost-full through two write-clock stages
// - Almost-empty through two read-clock stages
// - Half-full set on write, cleared on read; the code lets the selected clock's view both set and clear it
module dcf_fifo_flags
  import dcf_pkg::*;
#(
  parameter int DEPTH = DCF_DEPTH_DEF
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic read_clock,
  input wire logic master_reset_n,
  input wire logic partial_reset_n,
  input wire logic sync_clock_select,
  input wire logic fall_through_mode,
  input wire logic offset_load_n,
  input wire logic prog_offset_enable,
  input wire logic [DCF_OFFS_W-1:0] prog_empty_offset,
  input wire logic [DCF_OFFS_W-1:0] prog_full_offset,
  input wire dcf_wr_type write_in,
  input wire logic read_enable_n,
  output logic [DCF_DATA_W-1:0] data_out,
  output logic full_flag_n,
  output logic input_ready_n,
  output logic almost_full_n,
  output logic half_full_n,
  output logic empty_flag_n,
  output logic output_ready_n,
  output logic almost_empty_n
);

  // ==========================================================
  // Sizes
  // ==========================================================
  localparam int ADDR_W = $clog2(DEPTH);
  localparam int PTR_W = ADDR_W + 1;
  localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
  localparam logic [PTR_W-1:0] HALF_P = PTR_W'(DEPTH / 2);

  // Pointer crossings assume a power-of-two depth within the offset width
  initial begin
    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0 || ADDR_W > DCF_OFFS_W) begin
      $error("dcf_fifo_flags: DEPTH must be a power of two, 4 to 32768");
    end
  end

  // ==========================================================
  // Write-clock side: strap and reset pins
  // ==========================================================
  logic [4:0] pins_s;
  logic mrs_s;
  logic prs_s;
  logic w_rst;
  logic w_master;

  // Every pin here is asynchronous, so each passes two flops first
  dcf_sync #(.W(5), .RST_VAL(5'h03)) u_pin_sync (
    .clock(clock),
    .srst(1'b0),
    .d({master_reset_n, partial_reset_n, sync_clock_select,
        fall_through_mode, offset_load_n}),
    .q(pins_s)
  );

  assign mrs_s = ~pins_s[4];
  assign prs_s = ~pins_s[3];
  assign w_master = srst | mrs_s;
  assign w_rst = w_master | prs_s;

  // ==========================================================
  // Modes latched at reset (select at any reset, the rest at master reset)
  // ==========================================================
  logic sel_reg;
  logic ft_reg;
  logic par_reg;

  // Select is taken only under reset, never during traffic
  always_ff @(posedge clock) begin
    if (w_rst) begin
      sel_reg <= pins_s[2];
    end
  end

  // Timing mode and offset loading method follow master reset or srst only, never partial reset
  always_ff @(posedge clock) begin
    if (w_master) begin
      ft_reg <= pins_s[1];
      par_reg <= ~pins_s[0];
    end
  end

  // ==========================================================
  // Offsets
  // ==========================================================
  logic [DCF_OFFS_W-1:0] eoff_reg;
  logic [DCF_OFFS_W-1:0] foff_reg;
  logic [DCF_OFFS_W-1:0] def_offs;

  assign def_offs = par_reg ? DCF_OFFS_PARALLEL : DCF_OFFS_SERIAL;

  // Unprogrammed offsets fall back to the default of the load method
  always_ff @(posedge clock) begin
    if (prog_offset_enable) begin
      eoff_reg <= prog_empty_offset;
      foff_reg <= prog_full_offset;
    end else begin
      eoff_reg <= def_offs;
      foff_reg <= def_offs;
    end
  end

  // ==========================================================
  // Storage
  // ==========================================================
  logic [DCF_DATA_W-1:0] mem [DEPTH];

  // ==========================================================
  // Write-clock side: pointers
  // ==========================================================
  logic [PTR_W-1:0] wptr_reg;
  logic [DCF_OFFS_W:0] wgray_reg;
  logic [DCF_OFFS_W:0] rgray_w;
  logic [DCF_OFFS_W:0] cgray_w;
  logic [PTR_W-1:0] rptr_w;
  logic [PTR_W-1:0] cptr_w;
  logic [PTR_W-1:0] wcount;
  logic [PTR_W-1:0] wtotal;
  logic wr_go;

  assign rptr_w = PTR_W'(dcf_gray2bin(rgray_w));
  assign cptr_w = PTR_W'(dcf_gray2bin(cgray_w));
  // Memory words only; the output register word is not stored content
  assign wcount = wptr_reg - rptr_w;
  // Everything not yet taken by the reader, output register included
  assign wtotal = wptr_reg - cptr_w;
  // No space means the write is dropped in either mode
  assign wr_go = ~write_in.enable_n & (wcount < DEPTH_P);

  // Write pointer, cleared by any reset
  always_ff @(posedge clock) begin
    if (w_rst) begin
      wptr_reg <= '0;
      wgray_reg <= '0;
    end else if (wr_go) begin
      wptr_reg <= wptr_reg + 1'b1;
      wgray_reg <= dcf_bin2gray((DCF_OFFS_W + 1)'(PTR_W'(wptr_reg + 1'b1)));
    end
  end

  // Array write; storage needs no reset
  always_ff @(posedge clock) begin
    if (wr_go && !w_rst) begin
      mem[wptr_reg[ADDR_W-1:0]] <= write_in.data;
    end
  end

  // ==========================================================
  // Write-clock side: flags, two stages each
  // ==========================================================
  logic full_s1;
  logic ir_s1;
  logic paf_s1;
  logic hf_s1;
  logic hf_r_w;

  // Flags only move on write edges, so a stalled writer freezes them
  always_ff @(posedge clock) begin
    if (w_rst) begin
      full_s1 <= DCF_RST_FULL_N;
      ir_s1 <= DCF_RST_IR_N;
      paf_s1 <= DCF_RST_PAF_N;
      full_flag_n <= DCF_RST_FULL_N;
      input_ready_n <= DCF_RST_IR_N;
      almost_full_n <= DCF_RST_PAF_N;
    end else begin
      full_s1 <= ~(wcount == DEPTH_P);
      ir_s1 <= (wtotal > DEPTH_P);
      paf_s1 <= ~(wcount >= DEPTH_P - PTR_W'(foff_reg));
      full_flag_n <= full_s1;
      input_ready_n <= ir_s1;
      almost_full_n <= paf_s1;
    end
  end

  // Half-full: the selected clock's occupancy view drives the flag.
  // Select high: the write-side view both sets and releases it; select low:
  // the read-side view is carried over and both sets and releases it.
  always_ff @(posedge clock) begin
    if (w_rst) begin
      hf_s1 <= DCF_RST_HF_N;
      half_full_n <= DCF_RST_HF_N;
    end else begin
      hf_s1 <= sel_reg ? ~(wcount > HALF_P) : hf_r_w;
      half_full_n <= hf_s1;
    end
  end

  // ==========================================================
  // Crossings into the read clock
  // ==========================================================
  logic r_rst;
  logic ft_r;
  logic [DCF_OFFS_W:0] wgray_r;
  logic [DCF_OFFS_W-1:0] eoff_r;

  // Reset level reaches the read side two read edges later
  dcf_sync #(.W(1), .RST_VAL(1'h1)) u_rst_r (
    .clock(read_clock),
    .srst(1'b0),
    .d(w_rst),
    .q(r_rst)
  );

  // Mode and offset are static outside reset, so flops suffice
  dcf_sync #(.W(DCF_OFFS_W + 1)) u_cfg_r (
    .clock(read_clock),
    .srst(1'b0),
    .d({ft_reg, eoff_reg}),
    .q({ft_r, eoff_r})
  );

  dcf_sync #(.W(DCF_OFFS_W + 1)) u_wptr_r (
    .clock(read_clock),
    .srst(r_rst),
    .d(wgray_reg),
    .q(wgray_r)
  );

  // ==========================================================
  // Read-clock side: pointers and output register
  // ==========================================================
  logic [PTR_W-1:0] rptr_reg;
  logic [PTR_W-1:0] cptr_reg;
  logic [DCF_OFFS_W:0] rgray_reg;
  logic [DCF_OFFS_W:0] cgray_reg;
  logic [PTR_W-1:0] wptr_r;
  logic [PTR_W-1:0] rcount;
  dcf_out_type out_state_reg;
  logic mem_has;
  logic std_rd;
  logic ft_take;
  logic ft_load;
  logic pop;

  assign wptr_r = PTR_W'(dcf_gray2bin(wgray_r));
  // Stored words only, never the held output word
  assign rcount = wptr_r - rptr_reg;
  assign mem_has = (rcount != '0);
  // Standard read waits for the flag, and stops at empty
  assign std_rd = ~ft_r & ~read_enable_n & empty_flag_n & mem_has;
  // Fall-through read needs a held word that the flag already shows
  assign ft_take = ft_r & ~read_enable_n & ~output_ready_n &
                   (out_state_reg == DCF_OUT_HELD);
  // Refill the output register when it is free or being taken
  assign ft_load = ft_r & mem_has &
                   ((out_state_reg == DCF_OUT_EMPTY) | ft_take);
  assign pop = std_rd | ft_load;

  // Memory-side read pointer
  always_ff @(posedge read_clock) begin
    if (r_rst) begin
      rptr_reg <= '0;
      rgray_reg <= '0;
    end else if (pop) begin
      rptr_reg <= rptr_reg + 1'b1;
      rgray_reg <= dcf_bin2gray((DCF_OFFS_W + 1)'(PTR_W'(rptr_reg + 1'b1)));
    end
  end

  // Consumed pointer: words the reader has actually taken
  always_ff @(posedge read_clock) begin
    if (r_rst) begin
      cptr_reg <= '0;
      cgray_reg <= '0;
    end else if (std_rd || ft_take) begin
      cptr_reg <= cptr_reg + 1'b1;
      cgray_reg <= dcf_bin2gray((DCF_OFFS_W + 1)'(PTR_W'(cptr_reg + 1'b1)));
    end
  end

  // Output register occupancy engine for fall-through mode
  always_ff @(posedge read_clock) begin
    if (r_rst) begin
      out_state_reg <= DCF_OUT_EMPTY;
    end else begin
      unique case (out_state_reg)
        DCF_OUT_EMPTY: begin
          if (ft_load) begin
            out_state_reg <= DCF_OUT_HELD;
          end
        end
        DCF_OUT_HELD: begin
          if (ft_take && !ft_load) begin
            out_state_reg <= DCF_OUT_EMPTY;
          end
        end
      endcase
    end
  end

  // Output data; the pointer crossing keeps the addressed word stable
  always_ff @(posedge read_clock) begin
    if (r_rst) begin
      data_out <= '0;
    end else if (pop) begin
      data_out <= mem[rptr_reg[ADDR_W-1:0]];
    end
  end

  // ==========================================================
  // Read-clock side: flags, two stages each
  // ==========================================================
  logic ef_s1;
  logic or_s1;
  logic pae_s1;
  logic hf_r_reg;

  // Flags only move on read edges, so a stalled reader freezes them
  always_ff @(posedge read_clock) begin
    if (r_rst) begin
      ef_s1 <= DCF_RST_EF_N;
      or_s1 <= DCF_RST_OR_N;
      pae_s1 <= DCF_RST_PAE_N;
      empty_flag_n <= DCF_RST_EF_N;
      output_ready_n <= DCF_RST_OR_N;
      almost_empty_n <= DCF_RST_PAE_N;
    end else begin
      // Drops at once when the last word leaves, so no read slips past
      ef_s1 <= mem_has & ~(std_rd & (rcount == PTR_W'(1)));
      or_s1 <= ~(out_state_reg == DCF_OUT_HELD) | (ft_take & ~ft_load); // Last take
      pae_s1 <= (rcount > PTR_W'(eoff_r));
      empty_flag_n <= ef_s1 & ~(std_rd & (rcount == PTR_W'(1)));
      // One extra read edge through the engine makes fall-through slower
      output_ready_n <= or_s1 | (ft_take & ~ft_load);
      almost_empty_n <= pae_s1;
    end
  end

  // Read-side half-full view, cleared on the read edge after the draining read
  always_ff @(posedge read_clock) begin
    if (r_rst) begin
      hf_r_reg <= DCF_RST_HF_N;
    end else begin
      hf_r_reg <= ~(rcount > HALF_P);
    end
  end

  // ==========================================================
  // Crossings into the write clock
  // ==========================================================
  dcf_sync #(.W(DCF_OFFS_W + 1)) u_rptr_w (
    .clock(clock),
    .srst(w_rst),
    .d(rgray_reg),
    .q(rgray_w)
  );

  dcf_sync #(.W(DCF_OFFS_W + 1)) u_cptr_w (
    .clock(clock),
    .srst(w_rst),
    .d(cgray_reg),
    .q(cgray_w)
  );

  dcf_sync #(.W(1), .RST_VAL(1'h1)) u_hf_w (
    .clock(clock),
    .srst(w_rst),
    .d(hf_r_reg),
    .q(hf_r_w)
  );

endmodule

//--- logic/dcf_pkg.sv
// Shared constants, types and pointer helpers of the dual-clock FIFO flag block.
// Assumes: used by logic/dcf_fifo_flags.sv, logic/dcf_sync.sv and the testbench modules.
package dcf_pkg;

  // ==========================================================
  // Widths and sizes
  // ==========================================================
  localparam int DCF_DATA_W = 9;
  localparam int DCF_DEPTH_DEF = 16384;
  localparam int DCF_OFFS_W = 15;
  localparam int DCF_SYNC_STAGES = 2;

  // ==========================================================
  // Default offsets picked at master reset
  // ==========================================================
  localparam logic [DCF_OFFS_W-1:0] DCF_OFFS_PARALLEL = 15'h007F;
  localparam logic [DCF_OFFS_W-1:0] DCF_OFFS_SERIAL = 15'h03FF;

  // ==========================================================
  // Reset values of the flag outputs (empty-state pattern)
  // ==========================================================
  localparam logic DCF_RST_FULL_N = 1'h1;
  localparam logic DCF_RST_IR_N = 1'h0;
  localparam logic DCF_RST_PAF_N = 1'h1;
  localparam logic DCF_RST_HF_N = 1'h1;
  localparam logic DCF_RST_EF_N = 1'h0;
  localparam logic DCF_RST_OR_N = 1'h1;
  localparam logic DCF_RST_PAE_N = 1'h0;

  // ==========================================================
  // Types
  // ==========================================================
  // Write port request as seen on the write clock
  typedef struct packed {
    logic enable_n;
    logic [DCF_DATA_W-1:0] data;
  } dcf_wr_type;

  // Output register state in fall-through mode
  typedef enum logic [0:0] {
    DCF_OUT_EMPTY = 1'b0,
    DCF_OUT_HELD = 1'b1
  } dcf_out_type;

  // ==========================================================
  // Pointer coding for the clock crossings
  // ==========================================================
  function automatic logic [DCF_OFFS_W:0] dcf_bin2gray(input logic [DCF_OFFS_W:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [DCF_OFFS_W:0] dcf_gray2bin(input logic [DCF_OFFS_W:0] g);
    logic [DCF_OFFS_W:0] b;
    b = '0;
    for (int i = DCF_OFFS_W; i >= 0; i--) begin
      b[i] = (i == DCF_OFFS_W) ? g[i] : (b[i+1] ^ g[i]);
    end
    return b;
  endfunction

endpackage

//--- logic/dcf_sync.sv
// Two-flop synchroniser for levels and gray-coded words.
// Assumes: input is a level or a gray code that changes one bit at a time.
`timescale 1ns/1ps
module dcf_sync
  import dcf_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ==========================================================
  // Synchroniser chain
  // ==========================================================
  logic [W-1:0] meta_reg;

  // First stage is read only by the second stage
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

//--- testbench/dcf_fifo_flags_monitor.sv
// Checker of flag timing relations for the dual-clock FIFO flag block.
// Assumes: sees only the top module ports; attached by the bind below.
`timescale 1ns/1ps
module dcf_fifo_flags_monitor
  import dcf_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic read_clock,
  input wire logic master_reset_n,
  input wire logic partial_reset_n,
  input wire logic fall_through_mode,
  input wire dcf_wr_type write_in,
  input wire logic read_enable_n,
  input wire logic [DCF_DATA_W-1:0] data_out,
  input wire logic full_flag_n,
  input wire logic input_ready_n,
  input wire logic almost_full_n,
  input wire logic empty_flag_n,
  input wire logic output_ready_n,
  input wire logic almost_empty_n
);
  // ==========
  // Helpers
  // ==========
  logic [3:0] calm_reg;
  logic [5:0] wr_hist_reg;
  logic [5:0] rd_hist_reg;
  logic quiet;
  // Read side leaves reset late, so checks wait 12 cycles after any reset
  always_ff @(posedge clock) begin
    if (srst || !master_reset_n || !partial_reset_n) begin
      calm_reg <= 4'h0;
    end else if (calm_reg != 4'hF) begin
      calm_reg <= calm_reg + 4'h1;
    end
  end
  assign quiet = srst || !master_reset_n || !partial_reset_n || (calm_reg < 4'hC);
  // Recent strobes of each port, newest in bit 0
  always_ff @(posedge clock) begin
    wr_hist_reg <= {wr_hist_reg[4:0], !write_in.enable_n};
  end
  always_ff @(posedge read_clock) begin
    rd_hist_reg <= {rd_hist_reg[4:0], !read_enable_n};
  end
  // ==========
  // Assertions
  // ==========
  a_full_af_order: assert property (@(posedge clock) disable iff (quiet)
    !full_flag_n |-> !almost_full_n) else $error("full without almost full");
  a_ir_full_pair: assert property (@(posedge clock) disable iff (quiet)
    input_ready_n |-> !full_flag_n) else $error("not ready while memory not full");
  a_full_lag: assert property (@(posedge clock) disable iff (quiet)
    $fell(full_flag_n) |-> |wr_hist_reg[4:1]) else $error("full with no recent write");
  a_af_lag: assert property (@(posedge clock) disable iff (quiet)
    $fell(almost_full_n) |-> |wr_hist_reg[4:1]) else $error("almost full with no write");
  a_empty_blocks: assert property (@(posedge read_clock) disable iff (quiet)
    !fall_through_mode && !empty_flag_n && !read_enable_n |=> $stable(data_out))
    else $error("read taken while empty");
  a_or_hold: assert property (@(posedge read_clock) disable iff (quiet)
    fall_through_mode && !output_ready_n && read_enable_n |=> $stable(data_out))
    else $error("held word changed without a read");
  a_empty_ae_pair: assert property (@(posedge read_clock) disable iff (quiet)
    !fall_through_mode && !empty_flag_n |-> !almost_empty_n)
    else $error("empty without almost empty");
  a_empty_lag: assert property (@(posedge read_clock) disable iff (quiet)
    !fall_through_mode && $fell(empty_flag_n) |-> |rd_hist_reg[4:0])
    else $error("empty with no recent read");
  a_ae_lag: assert property (@(posedge read_clock) disable iff (quiet)
    !fall_through_mode && $fell(almost_empty_n) |-> |rd_hist_reg[4:0])
    else $error("almost empty with no recent read");
  c_full: cover property (@(posedge clock) disable iff (quiet) $fell(full_flag_n));
  c_ir: cover property (@(posedge clock) disable iff (quiet) $rose(input_ready_n));
  c_or: cover property (@(posedge read_clock) disable iff (quiet) $fell(output_ready_n));
endmodule

bind dcf_fifo_flags dcf_fifo_flags_monitor u_mon (.clock(clock), .srst(srst),
  .read_clock(read_clock), .master_reset_n(master_reset_n),
  .partial_reset_n(partial_reset_n), .fall_through_mode(fall_through_mode),
  .write_in(write_in), .read_enable_n(read_enable_n), .data_out(data_out),
  .full_flag_n(full_flag_n), .input_ready_n(input_ready_n), .almost_full_n(almost_full_n),
  .empty_flag_n(empty_flag_n), .output_ready_n(output_ready_n),
  .almost_empty_n(almost_empty_n));

//--- testbench/dcf_port_model.sv
// Writer and reader standing at the two FIFO ports.
// Assumes: the bench calls its tasks; it drives on falling clock edges.
`timescale 1ns/1ps
module dcf_port_model
  import dcf_pkg::*;
(
  input wire logic clock,
  input wire logic read_clock,
  output dcf_wr_type write_in,
  output logic read_enable_n
);
  // ==========
  // Port drivers
  // ==========
  initial begin
    write_in = '{enable_n: 1'h1, data: '0};
    read_enable_n = 1'h1;
  end
  // One word per write clock; bursts run back to back until idle
  task automatic put(input logic [DCF_DATA_W-1:0] d);
    @(negedge clock);
    write_in <= '{enable_n: 1'h0, data: d};
  endtask
  // Released data shows its inverse so a stale word is never taken as valid
  task automatic idle();
    @(negedge clock);
    write_in <= '{enable_n: 1'h1, data: ~write_in.data};
  endtask
  // One strobe held over exactly one read clock edge
  task automatic take();
    @(negedge read_clock);
    read_enable_n <= 1'h0;
    @(negedge read_clock);
    read_enable_n <= 1'h1;
  endtask
endmodule

//--- testbench/tb_dual_clock_fifo_status_flags.sv
// Self-checking bench of the dual-clock FIFO flag block.
// Assumes: write clock 5 ns, read clock 6 ns, depth shrunk to 16.
`timescale 1ns/1ps
module tb_dual_clock_fifo_status_flags;
  import dcf_pkg::*;
  localparam int D = 16;
  localparam int M = 3;
  localparam int N = 2;
  logic clock = 1'h0;
  logic read_clock = 1'h0;
  logic rclk_run = 1'h1;
  logic srst = 1'h1;
  logic master_reset_n = 1'h0;
  logic partial_reset_n = 1'h1;
  logic fall_through_mode = 1'h0;
  logic sync_clock_select = 1'h1;
  logic prog_offset_enable = 1'h1;
  dcf_wr_type write_in;
  logic read_enable_n;
  logic [8:0] data_out;
  logic full_flag_n, input_ready_n, almost_full_n, half_full_n;
  logic empty_flag_n, output_ready_n, almost_empty_n;
  int mismatches = 0;
  int tests_run = 0;
  wire [4:0] flags = {full_flag_n, almost_full_n, half_full_n, almost_empty_n, empty_flag_n};
  // ==========
  // Clocks and instances
  // ==========
  initial forever #2.5 clock = ~clock;
  // Read clock stops low when gated, as the non-selected clock may
  initial begin
    #1.3;
    forever #3 read_clock = rclk_run & ~read_clock;
  end
  dcf_port_model pm (.clock(clock), .read_clock(read_clock), .write_in(write_in),
    .read_enable_n(read_enable_n));
  // Write clock is the faster, so its half-full view is selected
  // Clocks are separate here; a shared clock would need select low
  // Offset bits above the small values stay zero
  dcf_fifo_flags #(.DEPTH(D)) uut (.clock(clock), .srst(srst), .read_clock(read_clock),
    .master_reset_n(master_reset_n), .partial_reset_n(partial_reset_n),
    .sync_clock_select(sync_clock_select), .fall_through_mode(fall_through_mode),
    .offset_load_n(1'h0), .prog_offset_enable(prog_offset_enable),
    .prog_empty_offset(15'h0002), .prog_full_offset(15'h0003),
    .write_in(write_in), .read_enable_n(read_enable_n), .data_out(data_out),
    .full_flag_n(full_flag_n), .input_ready_n(input_ready_n), .almost_full_n(almost_full_n),
    .half_full_n(half_full_n), .empty_flag_n(empty_flag_n), .output_ready_n(output_ready_n),
    .almost_empty_n(almost_empty_n));
  // ==========
  // Shared tasks
  // ==========
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic [8:0] w(input int i);
    return 9'(9'h155 ^ i);
  endfunction
  // Long enough for both pointer crossings and two flag stages
  task automatic settle();
    repeat (14) @(negedge clock);
  endtask
  // Standard flag pattern for c words in memory
  task automatic flags_std(input int c);
    settle();
    check(9'(flags), 9'({c < D, c < D - M, c <= D / 2, c > N, c > 0}));
  endtask
  task automatic wait_or();
    int k;
    k = 0;
    while (output_ready_n !== 1'h0 && k < 40) begin
      @(negedge read_clock);
      k++;
    end
    if (output_ready_n !== 1'h0) begin
      mismatches++;
      test_done();
    end
  endtask
  // Mode strap only moves while master reset is low
  task automatic do_reset(input logic ft);
    @(negedge clock);
    fall_through_mode = ft;
    master_reset_n = 1'h0;
    repeat (10) @(negedge clock);
    master_reset_n = 1'h1;
    flags_std(0);
    check(9'({input_ready_n, output_ready_n}), 9'h001);
  endtask
  // ==========
  // Scenarios
  // ==========
  task automatic std_fill();
    do_reset(1'h0);
    for (int i = 1; i <= D; i++) begin
      pm.put(w(i));
      pm.idle();
      flags_std(i);
    end
    pm.put(9'h0EE);
    pm.idle();
    flags_std(D);
    for (int i = 1; i <= D; i++) begin
      pm.take();
      check(data_out, w(i));
      flags_std(D - i);
    end
    pm.take();
    check(data_out, w(D));
  endtask
  task automatic ft_run();
    do_reset(1'h1);
    pm.put(w(0));
    pm.idle();
    wait_or();
    check(data_out, w(0));
    for (int i = 1; i < D; i++) pm.put(w(i));
    pm.idle();
    settle();
    check(9'(input_ready_n), 9'h000);
    pm.put(w(D));
    pm.idle();
    settle();
    check(9'({input_ready_n, almost_full_n}), 9'h002);
    for (int i = 0; i <= D; i++) begin
      wait_or();
      check(data_out, w(i));
      pm.take();
    end
    settle();
    check(9'(output_ready_n), 9'h001);
  endtask
  task automatic rclk_stop();
    do_reset(1'h0);
    rclk_run = 1'h0;
    for (int i = 1; i <= 3; i++) pm.put(w(i));
    pm.idle();
    settle();
    check(9'({empty_flag_n, almost_empty_n, almost_full_n}), 9'h001);
    rclk_run = 1'h1;
    flags_std(3);
    // Defaults are switched in under reset so no flag falls during checks
    prog_offset_enable = 1'h0;
    partial_reset_n = 1'h0;
    repeat (10) @(negedge clock);
    partial_reset_n = 1'h1;
    flags_std(0);
    for (int i = 1; i <= 3; i++) pm.put(w(i));
    pm.idle();
    settle();
    check(9'({almost_empty_n, almost_full_n}), 9'h001);
  endtask
  // ==========
  // Main sequence
  // ==========
  initial begin
    repeat (3) @(negedge clock);
    srst = 1'h0;
    std_fill();
    ft_run();
    rclk_stop();
    test_done();
  end
endmodule
